// >>> logic/pmac_top.sv
// module: converter setup, sequencing, averaging and first results
`timescale 1ns/10ps
module pmac_top
  import pmac_pkg::*;
#(
  parameter int unsigned CONV_TICKS [8] = CONV_TIME_US
) (
  input  wire logic        core_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        spi_cs_b_i,
  input  wire logic        spi_sclk_i,
  input  wire logic        spi_mosi_i,
  output logic             spi_miso_o,
  output logic             spi_miso_oe_o,
  input  wire logic [19:0] adc_shunt_i,
  input  wire logic [19:0] adc_bus_i,
  input  wire logic [15:0] adc_temp_i,
  output logic [1:0]       adc_chan_o,
  output logic             converting_o,
  output logic             shunt_range_o,
  output logic [19:0]      current_result_o
);
  pmac_reg_if rif ();

  pmac_spi_link u_link (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .cs_b_i     (spi_cs_b_i),
    .sclk_i     (spi_sclk_i),
    .mosi_i     (spi_mosi_i),
    .miso_o     (spi_miso_o),
    .miso_oe_o  (spi_miso_oe_o),
    .rif        (rif.link)
  );

  // register file
  logic [1:0]  main_cfg_ff, nxt_main_cfg;
  logic [15:0] adc_cfg_ff, nxt_adc_cfg;
  logic [14:0] cal_ff, nxt_cal;
  logic [13:0] drift_ff, nxt_drift;
  logic        cfg_wr;

  assign cfg_wr = rif.wr_stb && rif.addr == ADDR_ADC_CFG;

  always_comb begin
    nxt_main_cfg = main_cfg_ff;
    nxt_adc_cfg  = adc_cfg_ff;
    nxt_cal      = cal_ff;
    nxt_drift    = drift_ff;
    if (rif.wr_stb) begin
      case (rif.addr)
        ADDR_MAIN_CFG: nxt_main_cfg = {rif.wdata[DCE_BIT], rif.wdata[RNG_BIT]};
        ADDR_ADC_CFG:  nxt_adc_cfg  = rif.wdata;
        ADDR_CAL:      nxt_cal      = rif.wdata[14:0];
        ADDR_DRIFT:    nxt_drift    = rif.wdata[13:0];
        default:       nxt_main_cfg = main_cfg_ff;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      main_cfg_ff <= MAIN_CFG_RST;
      adc_cfg_ff  <= ADC_CFG_RST;
      cal_ff      <= CAL_RST;
      drift_ff    <= DRIFT_RST;
    end else begin
      main_cfg_ff <= nxt_main_cfg;
      adc_cfg_ff  <= nxt_adc_cfg;
      cal_ff      <= nxt_cal;
      drift_ff    <= nxt_drift;
    end
  end

  logic signed [19:0] shunt_res_ff, nxt_shunt_res;
  logic signed [19:0] bus_res_ff, nxt_bus_res;
  logic signed [15:0] temp_res_ff, nxt_temp_res;

  always_comb begin
    case (rif.addr)
      ADDR_MAIN_CFG:  rif.rdata = {10'h000, main_cfg_ff[1], main_cfg_ff[0], 4'h0, 8'h00};
      ADDR_ADC_CFG:   rif.rdata = {adc_cfg_ff, 8'h00};
      ADDR_CAL:       rif.rdata = {1'b0, cal_ff, 8'h00};
      ADDR_DRIFT:     rif.rdata = {2'h0, drift_ff, 8'h00};
      ADDR_SHUNT_RES: rif.rdata = {shunt_res_ff, 4'h0};
      ADDR_BUS_RES:   rif.rdata = {bus_res_ff, 4'h0};
      default:        rif.rdata = 24'h000000;
    endcase
  end

  // one microsecond tick; conversion times count ticks, not core cycles
  logic [3:0] tdiv_ff, nxt_tdiv;
  logic       tick_ff, nxt_tick;

  always_comb begin
    nxt_tick = tdiv_ff == 4'(TICK_CYC - 1);
    nxt_tdiv = nxt_tick ? 4'h0 : tdiv_ff + 4'h1;
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tdiv_ff <= 4'h0;
      tick_ff <= 1'b0;
    end else begin
      tdiv_ff <= nxt_tdiv;
      tick_ff <= nxt_tick;
    end
  end

  // conversion sequencer
  function automatic logic [1:0] pick_ch(input logic [2:0] en, input logic [1:0] from);
    logic [1:0] r;
    r = CH_NONE;
    for (int i = 2; i >= 0; i--) begin
      if (en[i] && 2'(i) >= from) begin
        r = 2'(i);
      end
    end
    return r;
  endfunction

  pmac_state_e        state_ff, nxt_state;
  logic [1:0]         ch_ff, nxt_ch;
  logic [12:0]        tcnt_ff, nxt_tcnt;
  logic [9:0]         round_ff, nxt_round;
  logic signed [29:0] sum_ff [3];
  logic signed [29:0] nxt_sum [3];
  logic               pub_ff, nxt_pub;
  logic [2:0]         ct_code;
  logic [12:0]        ct_last;
  logic [9:0]         avg_last;
  logic [2:0]         en;
  logic signed [19:0] sample;
  logic [3:0]         wmode;

  assign en       = adc_cfg_ff[MODE_LSB +: 3];
  assign wmode    = rif.wdata[MODE_LSB +: 4];
  assign avg_last = 10'((1 << AVG_SHIFT[adc_cfg_ff[AVG_LSB +: 3]]) - 1);

  always_comb begin
    case (ch_ff)
      CH_BUS:   ct_code = adc_cfg_ff[BUS_CT_LSB +: 3];
      CH_SHUNT: ct_code = adc_cfg_ff[SHUNT_CT_LSB +: 3];
      default:  ct_code = adc_cfg_ff[TEMP_CT_LSB +: 3];
    endcase
    ct_last = 13'(CONV_TICKS[ct_code] - 1);
    case (ch_ff)
      CH_BUS:   sample = adc_bus_i;
      CH_SHUNT: sample = adc_shunt_i;
      default:  sample = {{4{adc_temp_i[15]}}, adc_temp_i};
    endcase
  end

  always_comb begin
    nxt_state     = state_ff;
    nxt_ch        = ch_ff;
    nxt_tcnt      = tcnt_ff;
    nxt_round     = round_ff;
    nxt_sum       = sum_ff;
    nxt_pub       = 1'b0;
    nxt_shunt_res = shunt_res_ff;
    nxt_bus_res   = bus_res_ff;
    nxt_temp_res  = temp_res_ff;
    if (cfg_wr) begin
      // any setup write restarts from scratch with the new fields
      nxt_tcnt  = 13'h0000;
      nxt_round = 10'h000;
      nxt_sum   = '{default: 30'sh0};
      nxt_ch    = pick_ch(wmode[2:0], CH_BUS);
      nxt_state = wmode[2:0] != 3'h0 ? ST_CONV : ST_SLEEP;
    end else begin
      case (state_ff)
        ST_CONV: begin
          if (tick_ff) begin
            if (tcnt_ff == ct_last) begin
              nxt_tcnt        = 13'h0000;
              nxt_sum[ch_ff]  = sum_ff[ch_ff] + 30'(sample);
              nxt_ch          = pick_ch(en, 2'(ch_ff + 2'h1));
              if (nxt_ch == CH_NONE) begin
                nxt_ch = pick_ch(en, CH_BUS);
                if (round_ff == avg_last) begin
                  // publish only once the whole averaging run is in
                  nxt_pub   = 1'b1;
                  nxt_round = 10'h000;
                  if (en[1]) begin
                    nxt_shunt_res = 20'(nxt_sum[1] >>> AVG_SHIFT[adc_cfg_ff[2:0]]);
                  end
                  if (en[0]) begin
                    nxt_bus_res = 20'(nxt_sum[0] >>> AVG_SHIFT[adc_cfg_ff[2:0]]);
                    if (nxt_bus_res[19]) begin
                      nxt_bus_res = 20'sh0;
                    end
                  end
                  if (en[2]) begin
                    nxt_temp_res = 16'(nxt_sum[2] >>> AVG_SHIFT[adc_cfg_ff[2:0]]);
                  end
                  nxt_sum = '{default: 30'sh0};
                  if (!adc_cfg_ff[MODE_LSB + 3]) begin
                    nxt_state = ST_HOLD;
                  end
                end else begin
                  nxt_round = round_ff + 10'h001;
                end
              end
            end else begin
              nxt_tcnt = tcnt_ff + 13'h0001;
            end
          end
        end
        ST_SLEEP: nxt_state = ST_SLEEP;
        ST_HOLD:  nxt_state = ST_HOLD;
        default:  nxt_state = ST_SLEEP;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_ff     <= ST_SLEEP;
      ch_ff        <= CH_BUS;
      tcnt_ff      <= 13'h0000;
      round_ff     <= 10'h000;
      sum_ff       <= '{default: 30'sh0};
      pub_ff       <= 1'b0;
      shunt_res_ff <= 20'sh0;
      bus_res_ff   <= 20'sh0;
      temp_res_ff  <= 16'sh0;
    end else begin
      state_ff     <= nxt_state;
      ch_ff        <= nxt_ch;
      tcnt_ff      <= nxt_tcnt;
      round_ff     <= nxt_round;
      sum_ff       <= nxt_sum;
      pub_ff       <= nxt_pub;
      shunt_res_ff <= nxt_shunt_res;
      bus_res_ff   <= nxt_bus_res;
      temp_res_ff  <= nxt_temp_res;
    end
  end

  // current from shunt result; narrow range raises the gain by four
  logic signed [17:0] cal_eff;
  logic signed [37:0] cur_prod;
  logic signed [9:0]  dtemp;
  logic signed [44:0] drift_prod;
  logic signed [19:0] cur_raw_ff, nxt_cur_raw;
  logic signed [19:0] current_ff, nxt_current;
  logic               pub_d_ff;

  always_comb begin
    cal_eff     = main_cfg_ff[0] ? {1'b0, cal_ff, 2'b00} : {3'b000, cal_ff};
    cur_prod    = shunt_res_ff * cal_eff;
    nxt_cur_raw = pub_ff ? cur_prod[CUR_SHIFT +: 20] : cur_raw_ff;
    dtemp       = 10'(temp_res_ff >>> TEMP_FRAC) - TEMP_REF_C;
    // ppm taken as 2^-20: about five percent light, traded for no divider
    drift_prod  = cur_raw_ff * $signed({1'b0, drift_ff}) * dtemp;
    nxt_current = current_ff;
    if (pub_d_ff) begin
      nxt_current = main_cfg_ff[1] ? 20'(cur_raw_ff - drift_prod[DRIFT_SHIFT +: 20]) : cur_raw_ff;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cur_raw_ff <= 20'sh0;
      current_ff <= 20'sh0;
      pub_d_ff   <= 1'b0;
    end else begin
      cur_raw_ff <= nxt_cur_raw;
      current_ff <= nxt_current;
      pub_d_ff   <= pub_ff;
    end
  end

  assign adc_chan_o       = ch_ff;
  assign converting_o     = state_ff[1];
  assign shunt_range_o    = main_cfg_ff[0];
  assign current_result_o = current_ff;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  sequence s_tick_gap;
    !tick_ff [*8] ##1 !tick_ff ##1 tick_ff;
  endsequence

  property p_cfg_rst;
    $rose(rst_b_i) |-> adc_cfg_ff == ADC_CFG_RST && cal_ff == CAL_RST && drift_ff == DRIFT_RST;
  endproperty
  a_cfg_rst: assert property (p_cfg_rst) else $error("setup reset value wrong");

  property p_shutdown;
    state_ff == ST_CONV |-> en != 3'h0;
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("converting in shutdown code");

  property p_single;
    pub_ff && !adc_cfg_ff[15] && !$past(cfg_wr) |-> state_ff == ST_HOLD ##1 state_ff == ST_HOLD || $past(cfg_wr);
  endproperty
  a_single: assert property (p_single) else $error("single shot did not stop");

  property p_cont;
    pub_ff && adc_cfg_ff[15] && !$past(cfg_wr) |-> state_ff == ST_CONV && round_ff == 10'h000;
  endproperty
  a_cont: assert property (p_cont) else $error("continuous mode stopped");

  property p_tick;
    tick_ff |=> s_tick_gap;
  endproperty
  a_tick: assert property (p_tick) else $error("microsecond tick period wrong");

  property p_avg;
    pub_ff |-> $past(round_ff) == $past(avg_last) && $past(tcnt_ff) == $past(ct_last);
  endproperty
  a_avg: assert property (p_avg) else $error("results published mid average");

  property p_reserved;
    rif.addr == ADDR_SHUNT_RES || rif.addr == ADDR_BUS_RES || rif.addr == ADDR_CAL |-> rif.rdata[3:0] == 4'h0
      && (rif.addr != ADDR_CAL || !rif.rdata[23]);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits not zero");

  property p_bus_pos;
    !bus_res_ff[19];
  endproperty
  a_bus_pos: assert property (p_bus_pos) else $error("bus result negative");

  property p_restart;
    cfg_wr && wmode[2:0] != 3'h0 |=> state_ff == ST_CONV && tcnt_ff == 13'h0000 && round_ff == 10'h000;
  endproperty
  a_restart: assert property (p_restart) else $error("setup write did not restart");

  property p_drift_off;
    pub_d_ff && !main_cfg_ff[1] |=> current_ff == $past(cur_raw_ff);
  endproperty
  a_drift_off: assert property (p_drift_off) else $error("drift applied while disabled");
endmodule

// >>> logic/pmac_pkg.sv
// package: constants and types of the power monitor converter control block
package pmac_pkg;
  localparam logic [5:0]  ADDR_MAIN_CFG  = 6'h00;
  localparam logic [5:0]  ADDR_ADC_CFG   = 6'h01;
  localparam logic [5:0]  ADDR_CAL       = 6'h02;
  localparam logic [5:0]  ADDR_DRIFT     = 6'h03;
  localparam logic [5:0]  ADDR_SHUNT_RES = 6'h04;
  localparam logic [5:0]  ADDR_BUS_RES   = 6'h05;
  localparam int          MODE_LSB       = 12;
  localparam int          BUS_CT_LSB     = 9;
  localparam int          SHUNT_CT_LSB   = 6;
  localparam int          TEMP_CT_LSB    = 3;
  localparam int          AVG_LSB        = 0;
  localparam int          DCE_BIT        = 5;
  localparam int          RNG_BIT        = 4;
  localparam logic [15:0] ADC_CFG_RST    = 16'hfb68;
  localparam logic [14:0] CAL_RST        = 15'h1000;
  localparam logic [13:0] DRIFT_RST      = 14'h0000;
  localparam logic [1:0]  MAIN_CFG_RST   = 2'h0;
  localparam int unsigned CLK_HZ         = 10_000_000;
  localparam int unsigned TICK_US        = 1;
  localparam int unsigned TICK_CYC       = CLK_HZ / 1_000_000 * TICK_US;
  localparam int unsigned CONV_TIME_US [8] = '{50, 84, 150, 280, 540, 1052, 2074, 4120};
  localparam int unsigned AVG_SHIFT [8]  = '{0, 2, 4, 6, 7, 8, 9, 10};
  localparam logic [4:0]  HDR_BITS       = 5'h08;
  localparam logic [4:0]  WR_BITS        = 5'h18;
  localparam logic [1:0]  CH_BUS         = 2'h0;
  localparam logic [1:0]  CH_SHUNT       = 2'h1;
  localparam logic [1:0]  CH_TEMP        = 2'h2;
  localparam logic [1:0]  CH_NONE        = 2'h3;
  localparam int          CUR_SHIFT      = 13;
  localparam int          TEMP_FRAC      = 7;
  localparam logic signed [9:0] TEMP_REF_C = 10'sh019;
  localparam int          DRIFT_SHIFT    = 20;

  typedef enum logic [2:0] {
    ST_SLEEP = 3'b001,
    ST_CONV  = 3'b010,
    ST_HOLD  = 3'b100
  } pmac_state_e;
endpackage

// >>> logic/pmac_reg_if.sv
// interface: register access between the serial link and the register file
`timescale 1ns/10ps
interface pmac_reg_if;
  logic [5:0]  addr;
  logic [23:0] rdata;
  logic        wr_stb;
  logic [15:0] wdata;
  modport link (output addr, output wr_stb, output wdata, input rdata);
  modport regs (input addr, input wr_stb, input wdata, output rdata);
endinterface

// >>> logic/pmac_spi_link.sv
// module: serial register link, sampled from the core clock
`timescale 1ns/10ps
module pmac_spi_link
  import pmac_pkg::*;
(
  input  wire logic core_clk_i,
  input  wire logic rst_b_i,
  input  wire logic cs_b_i,
  input  wire logic sclk_i,
  input  wire logic mosi_i,
  output logic      miso_o,
  output logic      miso_oe_o,
  pmac_reg_if.link  rif
);
  logic [2:0]  s1_ff, s2_ff;
  logic        sclk_d_ff;
  logic [4:0]  bcnt_ff, nxt_bcnt;
  logic [14:0] in_sr_ff, nxt_in_sr;
  logic [5:0]  addr_ff, nxt_addr;
  logic        rd_ff, nxt_rd;
  logic        ok_ff, nxt_ok;
  logic        load_ff, nxt_load;
  logic [23:0] out_sr_ff, nxt_out_sr;
  logic        miso_ff, nxt_miso;
  logic        oe_ff, nxt_oe;
  logic        wr_ff, nxt_wr;
  logic [15:0] wdata_ff, nxt_wdata;
  logic        cs_act, fall, rise;

  // pins cross into the core clock through two flops; only s2_ff is read
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s1_ff     <= 3'h4;
      s2_ff     <= 3'h4;
      sclk_d_ff <= 1'b0;
    end else begin
      s1_ff     <= {cs_b_i, sclk_i, mosi_i};
      s2_ff     <= s1_ff;
      sclk_d_ff <= s2_ff[1];
    end
  end

  assign cs_act = !s2_ff[2];
  assign fall   = sclk_d_ff && !s2_ff[1];
  assign rise   = !sclk_d_ff && s2_ff[1];

  always_comb begin
    nxt_bcnt   = bcnt_ff;
    nxt_in_sr  = in_sr_ff;
    nxt_addr   = addr_ff;
    nxt_rd     = rd_ff;
    nxt_ok     = ok_ff;
    nxt_load   = 1'b0;
    nxt_out_sr = out_sr_ff;
    nxt_miso   = miso_ff;
    nxt_oe     = cs_act;
    nxt_wr     = 1'b0;
    nxt_wdata  = wdata_ff;
    if (!cs_act) begin
      nxt_bcnt = 5'h00;
      nxt_miso = 1'b0;
      nxt_ok   = 1'b0;
    end else begin
      if (load_ff) begin
        nxt_out_sr = ok_ff ? rif.rdata : 24'h000000;
      end
      if (fall) begin
        nxt_in_sr = {in_sr_ff[13:0], s2_ff[0]};
        if (bcnt_ff != 5'h1f) begin
          nxt_bcnt = bcnt_ff + 5'h01;
        end
        if (bcnt_ff == HDR_BITS - 5'h01) begin
          nxt_addr = in_sr_ff[6:1];
          nxt_ok   = !in_sr_ff[0];
          nxt_rd   = s2_ff[0];
          nxt_load = 1'b1;
        end
        if (bcnt_ff == WR_BITS - 5'h01 && ok_ff && !rd_ff) begin
          nxt_wdata = {in_sr_ff[14:0], s2_ff[0]};
          nxt_wr    = 1'b1;
        end
      end
      // old contents leave on miso while a write shifts in
      if (rise && bcnt_ff >= HDR_BITS) begin
        nxt_miso   = out_sr_ff[23];
        nxt_out_sr = {out_sr_ff[22:0], 1'b0};
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bcnt_ff   <= 5'h00;
      in_sr_ff  <= 15'h0000;
      addr_ff   <= 6'h00;
      rd_ff     <= 1'b0;
      ok_ff     <= 1'b0;
      load_ff   <= 1'b0;
      out_sr_ff <= 24'h000000;
      miso_ff   <= 1'b0;
      oe_ff     <= 1'b0;
      wr_ff     <= 1'b0;
      wdata_ff  <= 16'h0000;
    end else begin
      bcnt_ff   <= nxt_bcnt;
      in_sr_ff  <= nxt_in_sr;
      addr_ff   <= nxt_addr;
      rd_ff     <= nxt_rd;
      ok_ff     <= nxt_ok;
      load_ff   <= nxt_load;
      out_sr_ff <= nxt_out_sr;
      miso_ff   <= nxt_miso;
      oe_ff     <= nxt_oe;
      wr_ff     <= nxt_wr;
      wdata_ff  <= nxt_wdata;
    end
  end

  assign miso_o     = miso_ff;
  assign miso_oe_o  = oe_ff;
  assign rif.addr   = addr_ff;
  assign rif.wr_stb = wr_ff;
  assign rif.wdata  = wdata_ff;

  property p_wr_hdr;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      wr_ff |-> ok_ff && !rd_ff && $past(bcnt_ff) == WR_BITS - 5'h01;
  endproperty
  a_wr_hdr: assert property (p_wr_hdr) else $error("write without a write header");

  property p_oe_cs;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      $rose(s2_ff[2]) |=> !miso_oe_o && !miso_o;
  endproperty
  a_oe_cs: assert property (p_oe_cs) else $error("miso driven after select release");
endmodule

// >>> bench/pmac_spi_host.sv
// host side model: serial main that frames register accesses
`timescale 1ns/10ps
module pmac_spi_host (
  input  wire logic core_clk_i,
  output logic      cs_b_o,
  output logic      sclk_o,
  output logic      mosi_o,
  input  wire logic miso_i
);
  // deselected and clock parked low outside frames
  initial begin
    cs_b_o = 1'b1;
    sclk_o = 1'b0;
    mosi_o = 1'b0;
  end

  // header then nb data bits, msb first; bits after the header are collected
  task automatic xfer(input logic [7:0] hdr, input logic [23:0] dat, input int nb, output logic [23:0] rd);
    logic [31:0] sh;
    sh = {hdr, dat << (24 - nb)};
    rd = 24'h000000;
    @(posedge core_clk_i);
    cs_b_o <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    for (int i = 0; i < 8 + nb; i++) begin
      // data moves while the clock is high, well away from the sampling fall
      sclk_o <= 1'b1;
      mosi_o <= sh[31];
      sh = sh << 1;
      repeat (4) @(posedge core_clk_i);
      sclk_o <= 1'b0;
      repeat (4) @(posedge core_clk_i);
      // output stands until the next rise, so take it just before
      if (i >= 8) rd = {rd[22:0], miso_i};
    end
    cs_b_o <= 1'b1;
    // released line flips so a stale level is never mistaken for data
    mosi_o <= ~mosi_o;
    repeat (8) @(posedge core_clk_i);
  endtask
endmodule

// >>> bench/tb.sv
// testbench: register access, conversion sequencing and result checks
`timescale 1ns/10ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module tb
  import pmac_pkg::*;
;
  localparam int unsigned TK [8]    = '{2, 4, 6, 8, 10, 12, 14, 16};
  localparam int          NAVG [8]  = '{1, 4, 16, 64, 128, 256, 512, 1024};
  localparam logic [23:0] RST_V [6] = '{24'h0, 24'hfb68, 24'h1000, 24'h0, 24'h0, 24'h0};
  logic        clk, rst_b, cs_b, sclk, mosi, miso, miso_oe, conv, range_q, conv_q;
  logic [19:0] shunt_v, bus_v, cur;
  logic [15:0] temp_v;
  logic [1:0]  chan;
  logic [2:0]  seen;
  logic [23:0] rd;
  int          dur, n_mismatch, num_checks;
  wire         miso_w;
  assign miso_w = miso_oe ? miso : 1'bz;

  pmac_top #(.CONV_TICKS(TK)) DUT (
    .core_clk_i       (clk),
    .rst_b_i          (rst_b),
    .spi_cs_b_i       (cs_b),
    .spi_sclk_i       (sclk),
    .spi_mosi_i       (mosi),
    .spi_miso_o       (miso),
    .spi_miso_oe_o    (miso_oe),
    .adc_shunt_i      (shunt_v),
    .adc_bus_i        (bus_v),
    .adc_temp_i       (temp_v),
    .adc_chan_o       (chan),
    .converting_o     (conv),
    .shunt_range_o    (range_q),
    .current_result_o (cur)
  );
  pmac_spi_host host (.core_clk_i(clk), .cs_b_o(cs_b), .sclk_o(sclk), .mosi_o(mosi), .miso_i(miso_w));

  // channels visited and length of the current busy stretch
  always @(posedge clk) begin
    conv_q <= conv;
    if (conv && !conv_q) begin
      seen <= 3'b001 << chan;
      dur  <= 1;
    end else if (conv) begin
      seen <= seen | (3'b001 << chan);
      dur  <= dur + 1;
    end
  end

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    host.xfer({a, 2'b00}, {8'h00, d}, 16, rd);
  endtask
  task automatic rchk(input string nm, input logic [5:0] a, input int nb, input logic [23:0] e);
    host.xfer({a, 2'b01}, 24'h000000, nb, rd);
    `CHK(nm, e, rd)
  endtask
  task automatic wait_idle(input int lim);
    int k;
    k = 0;
    while (conv !== 1'b0 && k < lim) begin
      @(posedge clk);
      k++;
    end
    if (k >= lim) begin
      n_mismatch++;
      $display("wrong value idle wait expected done seen timeout");
      print_verdict();
    end
  endtask
  task automatic run(input logic [15:0] setup, input int lim);
    wr(ADDR_ADC_CFG, setup);
    wait_idle(lim);
  endtask

  initial begin
    int k;
    rst_b = 1'b0;
    shunt_v = 20'h00000;
    bus_v = 20'h12345;
    temp_v = 16'h0000;
    n_mismatch = 0;
    num_checks = 0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 6; i++) rchk("reset", 6'(i), (i < 4) ? 16 : 24, RST_V[i]);
    wr(6'h3f, 16'h5a5a);
    rchk("unmapped", 6'h3f, 16, 24'h000000);
    host.xfer({ADDR_CAL, 2'b10}, 24'h001234, 16, rd);
    rchk("bad header", ADDR_CAL, 16, 24'h001000);
    wr(ADDR_CAL, 16'hffff);
    rchk("cal", ADDR_CAL, 16, 24'h007fff);
    wr(ADDR_DRIFT, 16'hffff);
    rchk("drift", ADDR_DRIFT, 16, 24'h003fff);
    // a shutdown write before each mode gives every converting mode a fresh busy stretch
    for (int m = 15; m > 0; m--) begin
      wr(ADDR_ADC_CFG, 16'h0000);
      `CHK("stopped", 1'b0, conv)
      wr(ADDR_ADC_CFG, 16'(m) << 12);
      k = 0;
      while (k < 400 && m % 8 != 0 && (m > 8 ? dur < 100 : conv !== 1'b0)) begin
        @(posedge clk);
        k++;
      end
      if (k >= 400) wait_idle(0);
      if (m % 8 != 0) `CHK("channels", 3'(m % 8), seen)
      `CHK("running", m > 8, conv)
    end
    rchk("setup", ADDR_ADC_CFG, 16, 24'h001000);
    rchk("bus", ADDR_BUS_RES, 24, 24'h123450);
    for (int ch = 0; ch < 3; ch++) begin
      for (int c = 0; c < 8; c++) begin
        run((16'h1000 << ch) | (16'(c) << (9 - 3 * ch)), 400);
        `CHK("conv time", 1'b1, (dur > TK[c] * 10 - 10) && (dur < TK[c] * 10 + 10))
      end
    end
    for (int a = 0; a < 8; a++) begin
      run(16'h2000 | 16'(a), 25000);
      `CHK("avg time", 1'b1, (dur > TK[0] * 10 * NAVG[a] - 10) && (dur <= TK[0] * 10 * NAVG[a]))
    end
    shunt_v <= 20'h00100;
    bus_v <= 20'hfff00;
    temp_v <= 16'h3e80;
    wr(ADDR_CAL, 16'h1000);
    wr(ADDR_DRIFT, 16'h0400);
    run(16'h7001, 2000);
    `CHK("avg all", 1'b1, (dur > 230) && (dur < 250))
    rchk("shunt", ADDR_SHUNT_RES, 24, 24'h001000);
    rchk("bus clamp", ADDR_BUS_RES, 24, 24'h000000);
    `CHK("current", 20'h00080, cur)
    wr(ADDR_MAIN_CFG, 16'h0010);
    `CHK("range", 1'b1, range_q)
    run(16'h7000, 2000);
    repeat (3) @(posedge clk);
    `CHK("current narrow", 20'h00200, cur)
    wr(ADDR_MAIN_CFG, 16'h0020);
    run(16'h7000, 2000);
    repeat (3) @(posedge clk);
    `CHK("current drift", 20'h00074, cur)
    wr(ADDR_MAIN_CFG, 16'h0000);
    wr(ADDR_CAL, 16'h2000);
    run(16'h7000, 2000);
    repeat (3) @(posedge clk);
    `CHK("current scale", 20'h00100, cur)
    shunt_v <= 20'h00200;
    wr(ADDR_ADC_CFG, 16'h21c1);
    rchk("held", ADDR_SHUNT_RES, 24, 24'h001000);
    wait_idle(2000);
    `CHK("restart time", 1'b1, (dur > 630) && (dur < 650))
    rchk("averaged", ADDR_SHUNT_RES, 24, 24'h002000);
    shunt_v <= 20'h00300;
    rchk("one shot", ADDR_SHUNT_RES, 24, 24'h002000);
    `CHK("one shot stop", 1'b0, conv)
    print_verdict();
  end
endmodule
